//--- rtl/uart_bridge_pkg.sv
/*
  Shared constants and types for the bridged serial port: clock rates, the
  default line setting, buffer geometry, register offsets, interrupt bit
  positions and the serial state enumerations.
  Assumes a single system clock; the 12 MHz reference is synthesised from it.
*/
package uart_bridge_pkg;

  // Clocks: the system clock and the reference that baud divisors count
  localparam int unsigned SYS_CLK_HZ = 25_000_000;
  localparam int unsigned REF_CLK_HZ = 12_000_000;
  localparam logic [25:0] REF_ACC_STEP = 26'(REF_CLK_HZ);
  localparam logic [25:0] REF_ACC_WRAP = 26'(SYS_CLK_HZ);
  localparam logic [23:0] REF_DIVIDEND = 24'(REF_CLK_HZ);

  // Line setting after reset: 19200 baud, 8 data bits, no parity, 1 stop bit
  localparam logic [23:0] DEFAULT_BAUD = 24'h004B00;
  localparam logic [23:0] DEFAULT_DIVISOR = 24'(REF_CLK_HZ / 19200);
  localparam int DATA_BITS = 8;

  // Buffers and the request-to-send trip level
  localparam int BUF_DEPTH = 64;
  localparam int RTS_TRIP = 63;

  // Register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] LINE_BAUD_OFF = 8'h04;
  localparam logic [7:0] TX_DATA_OFF = 8'h08;
  localparam logic [7:0] RX_DATA_OFF = 8'h0C;
  localparam logic [7:0] STATUS_OFF = 8'h10;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h14;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h18;
  localparam logic [7:0] DIVISOR_OFF = 8'h1C;

  // Control register fields
  localparam int CTRL_FLOW_BIT = 0;
  localparam int CTRL_INVERT_BIT = 1;
  localparam int CTRL_WAKE_BIT = 2;

  // Interrupt status / mask bit positions
  localparam int IRQ_W = 6;
  localparam int IRQ_RX_READY = 0;
  localparam int IRQ_TX_DONE = 1;
  localparam int IRQ_RX_OVERRUN = 2;
  localparam int IRQ_FRAMING = 3;
  localparam int IRQ_SUSPEND = 4;
  localparam int IRQ_RESUME = 5;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

endpackage

//--- rtl/byte_buffer.sv
/*
  Byte buffer of parameterised width and depth with a read pointer and a fill
  count. When full and told to overwrite, a push replaces the last entry and
  the pointers stay put.
  Assumes the caller checks empty before relying on pop_data.
*/
`timescale 1ns/1ps
module byte_buffer import uart_bridge_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64,
  localparam int AW = $clog2(DEPTH),
  localparam int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk, // System clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic push, // Write one entry
  input wire logic [WIDTH-1:0] push_data, // Entry to write
  input wire logic overwrite, // When full, replace the last entry
  input wire logic pop, // Drop the oldest entry
  output logic [WIDTH-1:0] pop_data, // Oldest entry
  output logic [CW-1:0] count, // Entries held
  output logic full, // Count equals depth
  output logic empty // Count is zero
);

  typedef struct packed {
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] fill;
  } buf_state_t;

  buf_state_t state_reg, state_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_pop, do_push, do_over;
  logic [AW-1:0] wr_idx;

  assign full = (state_reg.fill == CW'(DEPTH));
  assign empty = (state_reg.fill == '0);
  assign count = state_reg.fill;
  assign pop_data = mem[state_reg.rd_ptr];

  // Full without a pop: pointers frozen, the last slot takes the new byte
  always_comb begin
    do_pop = pop && !empty;
    do_over = push && full && !do_pop && overwrite;
    do_push = push && (!full || do_pop);
    wr_idx = state_reg.rd_ptr + state_reg.fill[AW-1:0];
    if (do_over) begin
      wr_idx = state_reg.rd_ptr - AW'(1);
    end
    state_next = state_reg;
    if (do_pop) begin
      state_next.rd_ptr = state_reg.rd_ptr + AW'(1);
    end
    state_next.fill = state_reg.fill + CW'(do_push) - CW'(do_pop);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage has no reset; only the pointers define what is valid
  always_ff @(posedge clk) begin
    if (do_push || do_over) begin
      mem[wr_idx] <= push_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

//--- rtl/baud_div.sv
/*
  Sequential restoring divider: quotient = int(reference / requested baud).
  Takes one cycle per quotient bit; busy while working, done for one cycle.
  Assumes start is only given with a non-zero baud.
*/
`timescale 1ns/1ps
module baud_div import uart_bridge_pkg::*; (
  input wire logic clk, // System clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic start, // Begin a division, one-cycle pulse
  input wire logic [23:0] baud, // Requested baud rate
  output logic busy, // Division in progress
  output logic done, // Quotient valid, one-cycle pulse
  output logic [23:0] quotient // Integer part of reference / baud
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [4:0] steps;
    logic [24:0] rem;
    logic [23:0] dvd;
    logic [23:0] den;
    logic [23:0] quo;
  } div_state_t;

  div_state_t state_reg, state_next;
  logic [24:0] trial;

  assign busy = state_reg.busy;
  assign done = state_reg.done;
  assign quotient = state_reg.quo;

  // One quotient bit per cycle, most significant first
  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    trial = {state_reg.rem[23:0], state_reg.dvd[23]};
    if (start && !state_reg.busy) begin
      state_next.busy = 1'b1;
      state_next.steps = 5'h18;
      state_next.rem = '0;
      state_next.dvd = REF_DIVIDEND;
      state_next.den = baud;
      state_next.quo = '0;
    end else if (state_reg.busy) begin
      state_next.dvd = {state_reg.dvd[22:0], 1'b0};
      if (trial >= {1'b0, state_reg.den}) begin
        state_next.rem = trial - {1'b0, state_reg.den};
        state_next.quo = {state_reg.quo[22:0], 1'b1};
      end else begin
        state_next.rem = trial;
        state_next.quo = {state_reg.quo[22:0], 1'b0};
      end
      state_next.steps = state_reg.steps - 5'h01;
      if (state_reg.steps == 5'h01) begin
        state_next.busy = 1'b0;
        state_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

//--- rtl/serial_bridge.sv
/*
  Serial side of a USB-to-serial bridge: 8N1 transmitter and receiver,
  64-byte buffers each way, RTS/CTS flow control, polarity inversion,
  suspend tracking and an AHB-Lite register slave with interrupts.
  Assumes the USB engine reports suspend, resume and bus reset as one-cycle
  pulses and reaches the port only through the registers.
*/
// Our own choices: the address map and register access over AHB-Lite.
// Summary of operation
// - Reset line setting is 19200 8N1, format fixed
// - Line coding write changes only the baud
// - Divisor is int(12 MHz / baud)
// - Primary rates 300 to 921600 via same divisor
// - Custom rates use the same divider
// - RTS active low means ready to receive
// - RTS deasserts at 63 received characters held
// - CTS sampled just before loading each character
// - Character in flight always completes
// - Full receive buffer overwrites last slot
// - Separate 64-byte transmit and receive buffers
// - Serial input is only data, never control
// - Enter suspend on USB suspend signalling
// - Leave suspend on resume, bus or device reset
// - Flow control enable bit gates RTS/CTS
// - Invert setting flips data and handshake polarity
`timescale 1ns/1ps
module serial_bridge import uart_bridge_pkg::*; #(
  parameter logic FLOW_DEFAULT = 1'b1,
  parameter logic INVERT_DEFAULT = 1'b0,
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic clk, // 25 MHz system clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic hreadyout, // Always ready
  output logic hresp, // Always OKAY
  output logic [31:0] hrdata, // AHB read data
  output logic irq, // Level interrupt
  input wire logic usb_suspend, // Suspend signalling seen, pulse
  input wire logic usb_resume, // Resume signalling seen, pulse
  input wire logic usb_bus_reset, // USB bus reset seen, pulse
  output logic suspended, // Device in suspend
  output logic tx_pin, // Serial data out
  input wire logic rx_pin, // Serial data in
  output logic rts_pin, // Request to send
  input wire logic cts_pin // Clear to send
);

  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic flow_en;
    logic invert;
    logic suspended;
    logic [23:0] baud;
    logic [23:0] divisor;
    logic div_start;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [25:0] ref_acc;
    tx_state_t tx_state;
    logic [2:0] tx_bit;
    logic [23:0] tx_cnt;
    logic [7:0] tx_shift;
    logic tx_line;
    rx_state_t rx_state;
    logic [2:0] rx_bit;
    logic [23:0] rx_cnt;
    logic [7:0] rx_shift;
    logic ahb_wr;
    logic [7:0] ahb_addr;
    logic [31:0] rdata;
  } bridge_state_t;

  bridge_state_t state_reg, state_next;

  logic ref_tick, tx_bit_end, rx_bit_end, rx_half;
  logic rx_norm, cts_active, rts_active, addr_ok;
  logic tx_load, tx_done_ev, rx_push, rx_ok_ev, rx_ferr_ev;
  logic rx_pop, tx_push;
  logic [IRQ_W-1:0] irq_set, irq_clr;
  logic [7:0] tx_head, rx_head;
  logic [CW-1:0] tx_count, rx_count;
  logic tx_full, tx_empty, rx_full, rx_empty;
  logic div_busy, div_done;
  logic [23:0] div_quo;

  ////////////////////////////////////////////////////////////////////////////
  // Buffers and divider
  byte_buffer #(.WIDTH(DATA_BITS), .DEPTH(DEPTH)) tx_buf (
    .clk(clk),
    .reset_n(reset_n),
    .push(tx_push),
    .push_data(hwdata[7:0]),
    .overwrite(1'b0),
    .pop(tx_load),
    .pop_data(tx_head),
    .count(tx_count),
    .full(tx_full),
    .empty(tx_empty)
  );

  // Receive side always overwrites when full; with flow control on, RTS
  // has already told the far end to stop one character earlier
  byte_buffer #(.WIDTH(DATA_BITS), .DEPTH(DEPTH)) rx_buf (
    .clk(clk),
    .reset_n(reset_n),
    .push(rx_push),
    .push_data(state_reg.rx_shift),
    .overwrite(1'b1),
    .pop(rx_pop),
    .pop_data(rx_head),
    .count(rx_count),
    .full(rx_full),
    .empty(rx_empty)
  );

  baud_div divider (
    .clk(clk),
    .reset_n(reset_n),
    .start(state_reg.div_start),
    .baud(state_reg.baud),
    .busy(div_busy),
    .done(div_done),
    .quotient(div_quo)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Line polarity and handshakes
  always_comb begin
    rx_norm = rx_pin ^ state_reg.invert;
    cts_active = state_reg.invert ? cts_pin : !cts_pin;
    rts_active = !(state_reg.flow_en && (rx_count >= CW'(RTS_TRIP)));
    rts_pin = state_reg.invert ? rts_active : !rts_active;
    tx_pin = state_reg.tx_line ^ state_reg.invert;
  end

  // Bus answers at once, so wait states never occur
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = state_reg.rdata;
  assign suspended = state_reg.suspended;
  assign irq = |(state_reg.irq_stat & state_reg.irq_mask);

  // Reference tick: fractional accumulator gives 12 MHz worth of ticks
  always_comb begin
    ref_tick = (state_reg.ref_acc + REF_ACC_STEP) >= REF_ACC_WRAP;
    tx_bit_end = ref_tick && (state_reg.tx_cnt == state_reg.divisor - 24'h000001);
    rx_bit_end = ref_tick && (state_reg.rx_cnt == state_reg.divisor - 24'h000001);
    rx_half = ref_tick && (state_reg.rx_cnt == {1'b0, state_reg.divisor[23:1]});
  end

  // Bus strobes: reads pop in the address phase, writes act in the data phase
  always_comb begin
    addr_ok = hsel && htrans[1] && hready;
    rx_pop = addr_ok && !hwrite && (haddr[7:0] == RX_DATA_OFF);
    tx_push = state_reg.ahb_wr && (state_reg.ahb_addr == TX_DATA_OFF) && !tx_full;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    state_next = state_reg;
    state_next.div_start = 1'b0;
    tx_load = 1'b0;
    tx_done_ev = 1'b0;
    rx_push = 1'b0;
    rx_ok_ev = 1'b0;
    rx_ferr_ev = 1'b0;
    irq_clr = '0;

    // Reference accumulator
    if (ref_tick) begin
      state_next.ref_acc = state_reg.ref_acc + REF_ACC_STEP - REF_ACC_WRAP;
    end else begin
      state_next.ref_acc = state_reg.ref_acc + REF_ACC_STEP;
    end

    // Transmitter: CTS checked only in idle, never mid-frame
    if (ref_tick) begin
      state_next.tx_cnt = tx_bit_end ? '0 : state_reg.tx_cnt + 24'h000001;
    end
    case (state_reg.tx_state)
      TX_IDLE: begin
        state_next.tx_line = 1'b1;
        state_next.tx_cnt = '0;
        if (!tx_empty && (!state_reg.flow_en || cts_active)) begin
          tx_load = 1'b1;
          state_next.tx_shift = tx_head;
          state_next.tx_line = 1'b0;
          state_next.tx_state = TX_START;
        end
      end
      TX_START: begin
        if (tx_bit_end) begin
          state_next.tx_line = state_reg.tx_shift[0];
          state_next.tx_bit = '0;
          state_next.tx_state = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tx_bit_end) begin
          state_next.tx_shift = {1'b0, state_reg.tx_shift[7:1]};
          state_next.tx_bit = state_reg.tx_bit + 3'h1;
          if (state_reg.tx_bit == 3'h7) begin
            state_next.tx_line = 1'b1;
            state_next.tx_state = TX_STOP;
          end else begin
            state_next.tx_line = state_reg.tx_shift[1];
          end
        end
      end
      TX_STOP: begin
        if (tx_bit_end) begin
          tx_done_ev = 1'b1;
          state_next.tx_state = TX_IDLE;
        end
      end
      default: state_next.tx_state = TX_IDLE;
    endcase

    // Receiver: received bytes go only to the buffer, never decoded
    if (ref_tick) begin
      state_next.rx_cnt = state_reg.rx_cnt + 24'h000001;
    end
    case (state_reg.rx_state)
      RX_IDLE: begin
        state_next.rx_cnt = '0;
        if (!rx_norm) begin
          state_next.rx_state = RX_START;
        end
      end
      RX_START: begin
        if (rx_half) begin
          state_next.rx_cnt = '0;
          state_next.rx_bit = '0;
          state_next.rx_state = rx_norm ? RX_IDLE : RX_DATA; // Glitch rejected
        end
      end
      RX_DATA: begin
        if (rx_bit_end) begin
          state_next.rx_cnt = '0;
          state_next.rx_shift = {rx_norm, state_reg.rx_shift[7:1]};
          state_next.rx_bit = state_reg.rx_bit + 3'h1;
          if (state_reg.rx_bit == 3'h7) begin
            state_next.rx_state = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rx_bit_end) begin
          state_next.rx_state = RX_IDLE;
          if (rx_norm) begin
            rx_push = 1'b1;
            rx_ok_ev = 1'b1;
          end else begin
            rx_ferr_ev = 1'b1;
          end
        end
      end
      default: state_next.rx_state = RX_IDLE;
    endcase

    // Divider result replaces the divisor; zero quotient clamps to one
    if (div_done) begin
      state_next.divisor = (div_quo == '0) ? 24'h000001 : div_quo;
    end

    // Suspend tracking; leaving it beats entering it in the same cycle
    if (usb_suspend) begin
      state_next.suspended = 1'b1;
    end
    if (usb_resume || usb_bus_reset) begin
      state_next.suspended = 1'b0;
    end

    // Bus address phase: latch the access and register read data
    state_next.ahb_wr = addr_ok && hwrite;
    if (addr_ok) begin
      state_next.ahb_addr = haddr[7:0];
    end
    if (addr_ok && !hwrite) begin
      case (haddr[7:0])
        CTRL_OFF: state_next.rdata = {30'h0, state_reg.invert, state_reg.flow_en};
        LINE_BAUD_OFF: state_next.rdata = {8'h00, state_reg.baud};
        RX_DATA_OFF: state_next.rdata = {24'h0, rx_empty ? 8'h00 : rx_head};
        STATUS_OFF: state_next.rdata = {10'h0, div_busy, cts_active, rts_active,
          state_reg.suspended, state_reg.rx_state != RX_IDLE,
          state_reg.tx_state != TX_IDLE, 1'b0, 7'(tx_count), 1'b0, 7'(rx_count)};
        IRQ_STAT_OFF: state_next.rdata = {26'h0, state_reg.irq_stat};
        IRQ_MASK_OFF: state_next.rdata = {26'h0, state_reg.irq_mask};
        DIVISOR_OFF: state_next.rdata = {8'h00, state_reg.divisor};
        default: state_next.rdata = 32'h0000_0000;
      endcase
    end

    // Bus data phase writes; only the baud field is taken from line coding
    if (state_reg.ahb_wr) begin
      case (state_reg.ahb_addr)
        CTRL_OFF: begin
          state_next.flow_en = hwdata[CTRL_FLOW_BIT];
          state_next.invert = hwdata[CTRL_INVERT_BIT];
          if (hwdata[CTRL_WAKE_BIT]) begin
            state_next.suspended = 1'b0;
          end
        end
        LINE_BAUD_OFF: begin
          if (hwdata[23:0] != '0 && !div_busy) begin
            state_next.baud = hwdata[23:0];
            state_next.div_start = 1'b1;
          end
        end
        IRQ_STAT_OFF: irq_clr = hwdata[IRQ_W-1:0];
        IRQ_MASK_OFF: state_next.irq_mask = hwdata[IRQ_W-1:0];
        default: ;
      endcase
    end

    // Sticky interrupt status: a set in the clearing cycle wins
    irq_set = '0;
    irq_set[IRQ_RX_READY] = rx_ok_ev;
    irq_set[IRQ_TX_DONE] = tx_done_ev;
    irq_set[IRQ_RX_OVERRUN] = rx_push && rx_full;
    irq_set[IRQ_FRAMING] = rx_ferr_ev;
    irq_set[IRQ_SUSPEND] = usb_suspend && !state_reg.suspended;
    irq_set[IRQ_RESUME] = state_reg.suspended && !state_next.suspended;
    state_next.irq_stat = (state_reg.irq_stat & ~irq_clr) | irq_set;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; the line setting comes up at 19200 8N1
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
      state_reg.flow_en <= FLOW_DEFAULT;
      state_reg.invert <= INVERT_DEFAULT;
      state_reg.baud <= DEFAULT_BAUD;
      state_reg.divisor <= DEFAULT_DIVISOR;
      state_reg.tx_line <= 1'b1;
      state_reg.tx_state <= TX_IDLE;
      state_reg.rx_state <= RX_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

//--- testbench/serial_bridge_chk.sv
/*
  Port checker for serial_bridge, bound to every instance.
  Assumes normal polarity and flow control on while serial traffic runs.
*/
`timescale 1ns/1ps
module serial_bridge_chk (
  input logic clk, // Clock
  input logic reset_n, // Reset, active low
  input logic hsel, // Slave select
  input logic [1:0] htrans, // Transfer type
  input logic hwrite, // Write
  input logic hready, // Bus ready
  input logic hreadyout, // Slave ready
  input logic hresp, // Response
  input logic [31:0] hrdata, // Read data
  input logic irq, // Interrupt
  input logic usb_suspend, // Suspend pulse
  input logic usb_resume, // Resume pulse
  input logic usb_bus_reset, // Bus reset pulse
  input logic suspended, // Suspend state
  input logic tx_pin, // Serial out
  input logic rts_pin // Request to send
);
  localparam int LOW_MAX = 12000;
  logic aph;
  logic wph;
  logic [15:0] low_cnt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  //////////////////////////////////////////////////////////////////////////////
  // Address phase, write data phase and length of the current low run on tx
  assign aph = hsel && htrans[1] && hready;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wph <= 1'b0;
      low_cnt <= 16'h0000;
    end else begin
      wph <= aph && hwrite;
      low_cnt <= tx_pin ? 16'h0000 : low_cnt + 16'h0001;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Falls need a bus access; only writes clear irq, while suspend also ends on resume or bus reset
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus not OKAY");
  AST_SUSP_ENTER: assert property (usb_suspend && !usb_resume && !usb_bus_reset |=> suspended)
    else $error("no suspend");
  AST_SUSP_LEAVE: assert property (usb_resume || usb_bus_reset |=> !suspended)
    else $error("no resume");
  AST_SUSP_HOLD: assert property (suspended && !usb_resume && !usb_bus_reset && !wph |=> suspended)
    else $error("stray resume");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wph))
    else $error("irq fell alone");
  AST_RTS_FALL: assert property ($fell(rts_pin) |-> $past(aph) || $past(aph, 2) || $past(aph, 3))
    else $error("rts fell alone");
  AST_HRDATA_HOLD: assert property (!(aph && !hwrite) |=> $stable(hrdata))
    else $error("hrdata moved");
  AST_TX_LOW_RUN: assert property (low_cnt < LOW_MAX)
    else $error("tx low too long");
  C_SUSP: cover property ($rose(suspended));
  C_IRQ: cover property ($rose(irq));
  C_RTS: cover property ($rose(rts_pin));
endmodule
bind serial_bridge serial_bridge_chk i_chk (.*);

//--- testbench/uart_peer.sv
/*
  Far-end serial device: sends and decodes 8N1 frames.
  Assumes BIT clocks per bit and normal polarity.
*/
`timescale 1ns/1ps
module uart_peer #(
  parameter int BIT = 25
) (
  input logic clk, // Clock
  input logic tx_pin, // Serial data from the bridge
  input logic rts_pin, // Bridge ready, active low
  input logic cts_on, // Bench asks for clear to send
  input logic ignore_rts, // Send even when not ready
  output logic rx_pin, // Serial data to the bridge
  output logic cts_pin // Clear to send, active low
);
  logic [7:0] got [0:31];
  logic [7:0] sh;
  logic bad = 1'b0;
  int got_n = 0;
  initial rx_pin = 1'b1;
  assign cts_pin = !cts_on;
  //////////////////////////////////////////////////////////////////////////////
  // Sender; caller enters just after a rising edge
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int k = 0; k < 9999 && rts_pin && !ignore_rts; k++) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      rx_pin <= f[i];
      repeat (BIT) @(posedge clk);
    end
  endtask
  // Receiver samples mid-bit; a start without clear to send is flagged
  always begin
    @(negedge tx_pin);
    if (cts_pin) bad = 1'b1;
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      sh = {tx_pin, sh[7:1]};
    end
    repeat (BIT) @(posedge clk);
    if (tx_pin !== 1'b1) bad = 1'b1;
    got[got_n[4:0]] = sh;
    got_n++;
  end
endmodule

//--- testbench/tb_serial_bridge.sv
/*
  Self-checking bench for serial_bridge with a far-end serial peer.
  Assumes zero-wait bus answers are waited for, never counted on.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_serial_bridge;
  import uart_bridge_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, cts_on = 1'b1, ignore_rts = 1'b0;
  logic hready, hreadyout, hresp, irq, suspended, tx_pin, rx_pin, rts_pin, cts_pin;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic usb_suspend = 1'b0, usb_resume = 1'b0, usb_bus_reset = 1'b0;
  logic [7:0] sent [0:64];
  int errors = 0, checked = 0, seed = 32'hE5E9, n;
  int rates [15] = '{300, 1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200, 230400,
    460800, 921600, 7777, 0, 1000000};
  always #20 clk = ~clk;
  assign hready = hreadyout;
  serial_bridge i_serial_bridge (.*);
  uart_peer i_uart_peer (.*);
  //////////////////////////////////////////////////////////////////////////////
  // Verdict, timeout and expected divisor
  task automatic end_of_test();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic tmo();
    errors++;
    end_of_test();
  endtask
  function automatic logic [31:0] div_of(input int b);
    return 32'(REF_CLK_HZ / b);
  endfunction
  // Bus master: hold each phase until hready is seen high
  task automatic wait_rdy();
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (hreadyout === 1'b1) break;
    end
    if (n == 100) tmo();
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic poll_div();
    int k;
    repeat (4) @(posedge clk);
    for (k = 0; k < 200; k++) begin
      bus(1'b0, STATUS_OFF, 32'h0);
      if (rd[21] === 1'b0) break;
    end
    if (k == 200) tmo();
  endtask
  task automatic wait_got(input int t);
    int k;
    for (k = 0; k < 3000; k++) begin
      @(posedge clk);
      if (i_uart_peer.got_n >= t) break;
    end
    if (k == 3000) tmo();
  endtask
  task automatic pulse(input logic [2:0] p);
    {usb_bus_reset, usb_resume, usb_suspend} <= p;
    @(posedge clk);
    {usb_bus_reset, usb_resume, usb_suspend} <= 3'h0;
    @(posedge clk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rdc(LINE_BAUD_OFF, {8'h00, DEFAULT_BAUD});
    rdc(DIVISOR_OFF, {8'h00, DEFAULT_DIVISOR});
    rdc(CTRL_OFF, 32'h1);
    rdc(IRQ_MASK_OFF, 32'h0);
    rdc(8'h24, 32'h0);
    rates[13] = 300 + int'($unsigned($random(seed)) % 999700);
    foreach (rates[i]) begin
      wr(LINE_BAUD_OFF, {8'hA5, 24'(rates[i])});
      poll_div();
      rdc(DIVISOR_OFF, div_of(rates[i]));
    end
    rdc(CTRL_OFF, 32'h1);
    for (int i = 0; i < 4; i++) begin
      sent[i] = 8'($random(seed));
      wr(TX_DATA_OFF, {24'h0, sent[i]});
    end
    wait_got(4);
    for (int i = 0; i < 4; i++) `CHK(i_uart_peer.got[i], sent[i])
    cts_on <= 1'b0;
    wr(TX_DATA_OFF, 32'h5A);
    repeat (600) @(posedge clk);
    `CHK(i_uart_peer.got_n, 4)
    `CHK(tx_pin, 1'b1)
    cts_on <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (tx_pin === 1'b0) break;
    end
    if (n == 100) tmo();
    cts_on <= 1'b0;
    wr(TX_DATA_OFF, 32'hC3);
    wait_got(5);
    `CHK(i_uart_peer.got[4], 8'h5A)
    repeat (600) @(posedge clk);
    `CHK(i_uart_peer.got_n, 5)
    cts_on <= 1'b1;
    wait_got(6);
    `CHK(i_uart_peer.got[5], 8'hC3)
    `CHK(i_uart_peer.bad, 1'b0)
    wr(CTRL_OFF, 32'h0);
    cts_on <= 1'b0;
    wr(TX_DATA_OFF, 32'h96);
    wait_got(7);
    `CHK(i_uart_peer.got[6], 8'h96)
    wr(CTRL_OFF, 32'h1);
    cts_on <= 1'b1;
    wr(IRQ_MASK_OFF, 32'h1 << IRQ_RX_READY);
    for (int i = 0; i < 65; i++) begin
      sent[i] = 8'($random(seed));
      ignore_rts = (i > 62);
      i_uart_peer.send(sent[i]);
      if (i == 0) `CHK(irq, 1'b1)
      if (i == 61) `CHK(rts_pin, 1'b0)
      if (i == 62) `CHK(rts_pin, 1'b1)
    end
    bus(1'b0, STATUS_OFF, 32'h0);
    `CHK(rd[6:0], 7'h40)
    wr(IRQ_STAT_OFF, 32'h1 << IRQ_RX_READY);
    @(posedge clk);
    `CHK(irq, 1'b0)
    for (int i = 0; i < 64; i++) begin
      bus(1'b0, RX_DATA_OFF, 32'h0);
      `CHK(rd[7:0], (i == 63) ? sent[64] : sent[i])
    end
    rdc(RX_DATA_OFF, 32'h0);
    `CHK(rts_pin, 1'b0)
    rdc(CTRL_OFF, 32'h1);
    rdc(LINE_BAUD_OFF, 32'h000F4240);
    wr(IRQ_MASK_OFF, 32'h1 << IRQ_SUSPEND);
    pulse(3'b001);
    `CHK(suspended, 1'b1)
    `CHK(irq, 1'b1)
    pulse(3'b010);
    `CHK(suspended, 1'b0)
    pulse(3'b001);
    pulse(3'b100);
    `CHK(suspended, 1'b0)
    pulse(3'b001);
    wr(CTRL_OFF, 32'h5);
    @(posedge clk);
    `CHK(suspended, 1'b0)
    wr(IRQ_STAT_OFF, 32'h3F);
    wr(IRQ_MASK_OFF, 32'h0);
    pulse(3'b001);
    `CHK(irq, 1'b0)
    bus(1'b0, IRQ_STAT_OFF, 32'h0);
    `CHK(rd[IRQ_SUSPEND], 1'b1)
    wr(CTRL_OFF, 32'h3);
    @(posedge clk);
    `CHK(tx_pin, 1'b0)
    `CHK(rts_pin, 1'b1)
    reset_n <= 1'b0;
    @(posedge clk);
    `CHK(suspended, 1'b0)
    `CHK(tx_pin, 1'b1)
    reset_n <= 1'b1;
    @(posedge clk);
    rdc(LINE_BAUD_OFF, {8'h00, DEFAULT_BAUD});
    end_of_test();
  end
endmodule
